// ---- dac_core.sv ----
// Dual sine/cosine decimation filters with arctangent angle stage
// Overview of operation
// R1: Sine and cosine each have their own bitstream input and filter.
// R2: Each filter yields one sample per 128 bitstream samples.
// R3: Bitstreams are sampled at about 500 kHz from an enable divider.
// R4: Filters low-pass the bitstream before down-sampling.
// R5: Each filter outputs a 15-bit word near 3.9 kHz.
// R6: Angle is computed from the word pair by iterative arctangent.
// R7: The angle has 13 bits of resolution.
// R8: The full 13-bit code range spans 180 degrees.
// R9: Each angle word is handed to the serial output stage.
// R10: Reset clears filters, angle computation and output path.
// R11: 14-bit word, code zero is 0 degrees, top bit low normally.
// R12: On error top bit high, low two bits hold the error code.
// R13: Magnet lost when both channel magnitudes are below threshold.
// R14: Angle register updates once per sample pair and holds between; with the queue full it waits for a pop and drops older pairs.
module dac_core #(
  parameter int unsigned               FIFO_DEPTH_P = dac_pkg::FIFO_DEPTH,
  parameter logic [dac_pkg::IN_W-2:0]  LOST_THR     = 14'h0100
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    sin_bit,
  input  wire logic                    cos_bit,
  output logic [dac_pkg::OUT_W-1:0]    angle_word,
  output dac_pkg::dac_pair_s           filt_pair,
  output logic                         filt_strobe,
  output logic [dac_pkg::OUT_W-1:0]    angle_data,
  output logic                         angle_valid,
  input  wire logic                    angle_ready
);
  import dac_pkg::*;

  typedef logic signed [ACC_W-1:0]  acc_t;
  typedef logic signed [CORD_W-1:0] cord_t;

  typedef struct packed {
    logic [N_CHAN-1:0][1:0]            sync;
    logic [DIV_W-1:0]                  div_cnt;
    logic [DEC_W-1:0]                  dec_cnt;
    logic [N_CHAN-1:0][N_STAGE-1:0][ACC_W-1:0] integ;
    logic [N_CHAN-1:0][N_STAGE-1:0][ACC_W-1:0] dly;
    dac_pair_s                         pair;
    logic                              pair_stb;
    dac_pair_s                         pend;
    logic                              pend_vld;
    dac_state_e                        state;
    logic [ITER_W-1:0]                 iter;
    logic [CORD_W-1:0]                 x;
    logic [CORD_W-1:0]                 y;
    logic [PH_W-1:0]                   z;
    logic                              lost;
    logic [1:0]                        settle;
    logic [OUT_W-1:0]                  angle;
    logic [OUT_W-1:0]                  result;
  } core_state_s;

  core_state_s       st_reg;
  core_state_s       st_next;
  logic [N_CHAN-1:0] bit_in;
  logic              fifo_in_ready;
  logic              fifo_in_valid;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Magnitude below threshold; most negative code cannot be small
  function automatic logic is_small(input logic signed [IN_W-1:0] w);
    logic [IN_W-1:0] mag;
    mag = w[IN_W-1] ? IN_W'(-w) : IN_W'(w);
    return (mag < {1'b0, LOST_THR});
  endfunction : is_small

  // Comb output scaled to 15 bits with positive full scale clamped
  function automatic logic [IN_W-1:0] scale_word(input acc_t c);
    acc_t s;
    s = c >>> ACC_SHIFT;
    if (s > acc_t'((1 << (IN_W - 1)) - 1)) begin
      return IN_W'((1 << (IN_W - 1)) - 1);
    end
    return s[IN_W-1:0];
  endfunction : scale_word

  assign bit_in[CH_SIN] = sin_bit;
  assign bit_in[CH_COS] = cos_bit;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic              bit_en;
    acc_t              step;
    acc_t              c0;
    acc_t              c1;
    acc_t              c2;
    cord_t             xs;
    cord_t             ys;
    dac_pair_s         p;
    logic [ANG_W-1:0]  ang;
    logic [PH_W-1:0]   zr;
    bit_en = 1'b0;
    step = '0;
    c0 = '0;
    c1 = '0;
    c2 = '0;
    xs = '0;
    ys = '0;
    p = '0;
    ang = '0;
    zr = '0;
    fifo_in_valid = 1'b0;
    st_next = st_reg;
    st_next.pair_stb = 1'b0;

    // Bitstream pins come from another domain: two stages first
    for (int ch = 0; ch < N_CHAN; ch++) begin
      st_next.sync[ch] = {st_reg.sync[ch][0], bit_in[ch]};  // R1
    end

    // Bit-rate enable; the filters advance only on this pulse
    bit_en = (st_reg.div_cnt == DIV_W'(BIT_DIV - 1));  // R3
    st_next.div_cnt = bit_en ? '0 : st_reg.div_cnt + 1'b1;

    // Third-order sinc: integrate +/-1 at bit rate, comb at 1/128
    if (bit_en) begin
      st_next.dec_cnt = st_reg.dec_cnt + 1'b1;
      for (int ch = 0; ch < N_CHAN; ch++) begin
        step = st_reg.sync[ch][1] ? acc_t'(1) : acc_t'(-1);
        st_next.integ[ch][0] = st_reg.integ[ch][0] + step;  // R4
        st_next.integ[ch][1] = st_reg.integ[ch][1] + st_reg.integ[ch][0];
        st_next.integ[ch][2] = st_reg.integ[ch][2] + st_reg.integ[ch][1];
      end
      if (st_reg.dec_cnt == DEC_W'(OSR - 1)) begin  // R2
        for (int ch = 0; ch < N_CHAN; ch++) begin
          c0 = st_reg.integ[ch][2] - st_reg.dly[ch][0];
          c1 = c0 - st_reg.dly[ch][1];
          c2 = c1 - st_reg.dly[ch][2];
          st_next.dly[ch][0] = st_reg.integ[ch][2];
          st_next.dly[ch][1] = c0;
          st_next.dly[ch][2] = c1;
          if (ch == CH_SIN) begin
            st_next.pair.sin_word = scale_word(c2);  // R5
          end else begin
            st_next.pair.cos_word = scale_word(c2);  // R5
          end
        end
        st_next.pair_stb = 1'b1;
      end
    end

    // Angle engine: x half-plane fold, then vectoring iterations
    unique case (st_reg.state)
      ST_IDLE: begin
        if (st_reg.pend_vld) begin
          p = st_reg.pend;
          st_next.pend_vld = 1'b0;
          st_next.lost = is_small(p.sin_word) && is_small(p.cos_word);  // R13
          xs = CORD_W'(p.cos_word);
          ys = CORD_W'(p.sin_word);
          if (xs < 0) begin
            st_next.x = -xs;
            st_next.y = -ys;
            st_next.z = PH_HALF;
          end else begin
            st_next.x = xs;
            st_next.y = ys;
            st_next.z = '0;
          end
          st_next.iter = '0;
          st_next.state = ST_ITER;
        end
      end
      ST_ITER: begin
        xs = cord_t'(st_reg.x);
        ys = cord_t'(st_reg.y);
        if (!ys[CORD_W-1]) begin
          st_next.x = xs + (ys >>> st_reg.iter);  // R6
          st_next.y = ys - (xs >>> st_reg.iter);
          st_next.z = st_reg.z + dac_atan(st_reg.iter);
        end else begin
          st_next.x = xs - (ys >>> st_reg.iter);  // R6
          st_next.y = ys + (xs >>> st_reg.iter);
          st_next.z = st_reg.z - dac_atan(st_reg.iter);
        end
        st_next.iter = st_reg.iter + 1'b1;
        if (st_reg.iter == ITER_W'(N_ITER - 1)) begin
          st_next.state = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // Inputs carry twice the mechanical angle, so one turn of
        // phase is 180 degrees of output code
        zr = st_reg.z + PH_W'(1 << (PH_DROP - 1));
        ang = zr[PH_W-1:PH_DROP];  // R7 R8
        if (st_reg.settle != 2'(SETTLE)) begin
          st_next.result = {1'b1, {(OUT_W-3){1'b0}}, ERR_NO_VALUE};  // R12
        end else if (st_reg.lost) begin
          st_next.result = {1'b1, ang[ANG_W-1:2], ERR_MAGNET_LOST};  // R12
        end else begin
          st_next.result = {1'b0, ang};  // R11
        end
        st_next.state = ST_IDLE;
      end
    endcase

    // Hand-off waits for room so no angle word is silently dropped;
    // iter keeps its end count until the queue takes the word
    if (st_reg.state == ST_IDLE && st_reg.iter == ITER_W'(N_ITER)) begin
      fifo_in_valid = 1'b1;  // R9
      st_next.iter = st_reg.iter;
      if (fifo_in_ready) begin
        st_next.angle = st_reg.result;  // R14
        st_next.iter = '0;
        if (st_reg.settle != 2'(SETTLE)) begin
          st_next.settle = st_reg.settle + 1'b1;
        end
      end
      st_next.state = ST_IDLE;
      st_next.pend_vld = st_reg.pend_vld;
    end

    // A new pair replaces an unstarted one; set wins over the clear
    if (st_reg.pair_stb) begin
      st_next.pend = st_reg.pair;
      st_next.pend_vld = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;  // R10
      st_reg.angle <= {1'b1, {(OUT_W-3){1'b0}}, ERR_NO_VALUE};
      st_reg.result <= {1'b1, {(OUT_W-3){1'b0}}, ERR_NO_VALUE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign angle_word  = st_reg.angle;  // R14
  assign filt_pair   = st_reg.pair;
  assign filt_strobe = st_reg.pair_stb;

  // ---------------------------------------------------------------
  // Output buffer toward the serial stage
  // ---------------------------------------------------------------
  dac_fifo #(
    .WIDTH (OUT_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (st_reg.result),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (angle_data),
    .out_valid (angle_valid),
    .out_ready (angle_ready)
  );

endmodule : dac_core

// ---- dac_pkg.sv ----
// Shared constants, types and lookup for the dual decimator angle core
package dac_pkg;

  // ---------------------------------------------------------------
  // Clocking and rates
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned BIT_RATE_HZ = 500_000;
  localparam int unsigned BIT_DIV     = CLK_HZ / BIT_RATE_HZ;
  localparam int unsigned DIV_W       = $clog2(BIT_DIV);

  // ---------------------------------------------------------------
  // Decimation filter
  // ---------------------------------------------------------------
  localparam int unsigned OSR       = 128;
  localparam int unsigned DEC_W     = $clog2(OSR);
  localparam int unsigned ACC_W     = 24;
  localparam int unsigned ACC_SHIFT = 7;
  localparam int unsigned IN_W      = 15;
  localparam int unsigned N_STAGE   = 3;
  localparam int unsigned N_CHAN    = 2;
  localparam int unsigned CH_SIN    = 0;
  localparam int unsigned CH_COS    = 1;
  localparam int unsigned SETTLE    = 3;

  // ---------------------------------------------------------------
  // Angle computation and output word
  // ---------------------------------------------------------------
  localparam int unsigned CORD_W    = 18;
  localparam int unsigned PH_W      = 16;
  localparam int unsigned PH_DROP   = 3;
  localparam int unsigned N_ITER    = 14;
  localparam int unsigned ITER_W    = 4;
  localparam int unsigned ANG_W     = 13;
  localparam int unsigned OUT_W     = 14;
  localparam int unsigned ERR_BIT   = 13;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [PH_W-1:0] PH_HALF   = 16'h8000;
  localparam logic [1:0] ERR_NO_VALUE    = 2'h0;
  localparam logic [1:0] ERR_MAGNET_LOST = 2'h1;

  typedef struct packed {
    logic signed [IN_W-1:0] sin_word;
    logic signed [IN_W-1:0] cos_word;
  } dac_pair_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ITER = 2'h1,
    ST_PUSH = 2'h3
  } dac_state_e;

  // Arctangent of 2^-i in units of a full turn over 2^16
  function automatic logic [PH_W-1:0] dac_atan(input logic [ITER_W-1:0] i);
    logic [PH_W-1:0] v;
    v = 16'h0000;
    unique case (i)
      4'h0: v = 16'h2000;
      4'h1: v = 16'h12E4;
      4'h2: v = 16'h09FB;
      4'h3: v = 16'h0511;
      4'h4: v = 16'h028B;
      4'h5: v = 16'h0146;
      4'h6: v = 16'h00A3;
      4'h7: v = 16'h0051;
      4'h8: v = 16'h0029;
      4'h9: v = 16'h0014;
      4'hA: v = 16'h000A;
      4'hB: v = 16'h0005;
      4'hC: v = 16'h0003;
      4'hD: v = 16'h0001;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : dac_atan

endpackage : dac_pkg

// ---- dac_fifo.sv ----
// Parameterised valid/ready FIFO for angle words
module dac_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import dac_pkg::*;

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = PTR_W + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
  } fifo_state_s;

  fifo_state_s st_reg;
  fifo_state_s st_next;
  logic        do_push;
  logic        do_pop;

  // ---------------------------------------------------------------
  // Handshakes
  // ---------------------------------------------------------------
  assign in_ready  = (st_reg.count != CNT_W'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[st_reg.rd_ptr];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // Pointer wrap is explicit so DEPTH need not be a power of two
  always_comb begin
    st_next = st_reg;
    if (do_push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = (st_reg.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 :
                       st_reg.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 :
                       st_reg.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (do_pop && !do_push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : dac_fifo

// ---- dac_core_properties.sv ----
// Concurrent port checks for the dual decimator angle core
module dac_core_properties (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 sin_bit,
  input wire logic                 cos_bit,
  input wire logic [13:0]          angle_word,
  input wire dac_pkg::dac_pair_s   filt_pair,
  input wire logic                 filt_strobe,
  input wire logic [13:0]          angle_data,
  input wire logic                 angle_valid,
  input wire logic                 angle_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import dac_pkg::*;

  localparam logic [15:0] GAP = 16'(OSR * BIT_DIV);

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  logic [15:0] gap_reg;
  logic        seen_reg;
  logic [10:0] since_reg;

  // Gap is only checked once a first strobe is seen: warm-up length is free
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_reg   <= 16'h0000;
      seen_reg  <= 1'b0;
      since_reg <= 11'h7FF;
    end else begin
      gap_reg   <= filt_strobe ? 16'h0001 : gap_reg + 16'h0001;
      seen_reg  <= seen_reg | filt_strobe;
      since_reg <= filt_strobe ? 11'h000
                   : since_reg + {10'h000, since_reg != 11'h7FF};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_strobe_gap_exact: assert property (
    filt_strobe && seen_reg |-> gap_reg == GAP)
    else $error("filter strobes not 128 bit periods apart");
  chk_strobe_one_cycle: assert property (
    filt_strobe |=> !filt_strobe [*8])
    else $error("filter strobe longer than one cycle");
  chk_pair_holds: assert property (
    !filt_strobe |-> $stable(filt_pair))
    else $error("filter pair moved without a strobe");
  // A stalled queue delays the push until the cycle after a pop
  chk_word_after_strobe: assert property (
    $changed(angle_word) |->
      since_reg < 11'h040 || $past(angle_valid && angle_ready, 2))
    else $error("angle word moved away from a sample pair");
  chk_error_code_legal: assert property (
    angle_word[ERR_BIT] |-> angle_word[1] == 1'b0)
    else $error("reserved error code in angle word");
  chk_push_follows: assert property (
    filt_strobe && !angle_valid |-> ##[2:40] angle_valid)
    else $error("no angle word handed on after a pair");
  chk_head_holds: assert property (
    angle_valid && !angle_ready |=> angle_valid && $stable(angle_data))
    else $error("queued angle word lost while stalled");
  chk_head_is_word: assert property (
    $rose(angle_valid) |-> angle_data == angle_word)
    else $error("handed word differs from angle word");
  chk_reset_clears: assert property (disable iff (1'b0)
    rst |-> angle_word == 14'h2000 && !angle_valid && !filt_strobe
            && filt_pair == '0)
    else $error("outputs not cleared in reset");

  cov_strobe: cover property (filt_strobe);
  cov_pop: cover property (angle_valid && angle_ready);
  cov_word: cover property ($changed(angle_word));
endmodule : dac_core_properties

bind dac_core dac_core_properties dac_core_properties_inst (
  .ref_clk(ref_clk), .rst(rst), .sin_bit(sin_bit), .cos_bit(cos_bit),
  .angle_word(angle_word), .filt_pair(filt_pair),
  .filt_strobe(filt_strobe), .angle_data(angle_data),
  .angle_valid(angle_valid), .angle_ready(angle_ready));

// ---- dac_mod_model.sv ----
// Behavioural pair of first-order modulators feeding the bitstream pins
module dac_mod_model (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [8:0] sin_lvl,
  input wire logic [8:0] cos_lvl,
  output logic           sin_bit,
  output logic           cos_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  import dac_pkg::*;

  int         div;
  logic [7:0] sin_acc;
  logic [7:0] cos_acc;

  // One bit per 500 kHz period; level 9'h100 is all ones, 0 all zeros.
  // Rising edge, so levels driven on the falling edge never race
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div     <= 0;
      sin_acc <= 8'h00;
      cos_acc <= 8'h00;
      sin_bit <= 1'b0;
      cos_bit <= 1'b0;
    end else if (div == BIT_DIV - 1) begin
      div <= 0;
      {sin_bit, sin_acc} <= {1'b0, sin_acc} + sin_lvl;
      {cos_bit, cos_acc} <= {1'b0, cos_acc} + cos_lvl;
    end else begin
      div <= div + 1;
    end
  end
endmodule : dac_mod_model

// ---- dac_core_test.sv ----
// Self-checking bench for the dual decimator angle core
module dac_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dac_pkg::*;

  logic             ref_clk;
  logic             rst;
  logic [8:0]       sin_lvl;
  logic [8:0]       cos_lvl;
  logic             sin_bit;
  logic             cos_bit;
  logic [OUT_W-1:0] angle_word;
  dac_pair_s        filt_pair;
  logic             filt_strobe;
  logic [OUT_W-1:0] angle_data;
  logic             angle_valid;
  logic             angle_ready;
  int               err_count;
  int               compares;
  integer           seed;
  int               gap;
  int               diff;
  int               popped;

  dac_core dac_core_inst (
    .ref_clk(ref_clk), .rst(rst), .sin_bit(sin_bit), .cos_bit(cos_bit),
    .angle_word(angle_word), .filt_pair(filt_pair),
    .filt_strobe(filt_strobe), .angle_data(angle_data),
    .angle_valid(angle_valid), .angle_ready(angle_ready));
  dac_mod_model dac_mod_model_inst (
    .ref_clk(ref_clk), .rst(rst), .sin_lvl(sin_lvl), .cos_lvl(cos_lvl),
    .sin_bit(sin_bit), .cos_bit(cos_bit));

  // 125 MHz clock
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // Expectations, checks and closing
  // ---------------------------------------------------------------
  // Warm-up word: error flag set, code no-value, angle bits clear
  function automatic logic [OUT_W-1:0] no_value_word();
    return {1'b1, 11'h000, ERR_NO_VALUE};
  endfunction : no_value_word

  // Settled filter word for a modulator level out of 256
  function automatic int expect_filt(input logic [8:0] lvl);
    int v;
    v = (int'(lvl) - 128) * 128;
    return (v > 16383) ? 16383 : v;
  endfunction : expect_filt

  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic summarize();
    $display("compares %0d, err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Bounded wait; strobe is seen at the falling edge inside its cycle
  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (filt_strobe !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      check(1'b0, "no filter strobe");
      summarize();
    end
  endtask : wait_strobe

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed        = 32'h0094d4ba;
    rst         = 1'b0;
    // Corner: full-scale sine; random cosine level kept negative
    sin_lvl     = 9'h100;
    cos_lvl     = 9'($unsigned($random(seed)) % 121);
    angle_ready = 1'b0;
    // A real rising edge on reset ahead of the first clock edge
    #1;
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    // Three warm-up words while the serial stage is stalled
    for (int k = 0; k < 3; k++) begin
      wait_strobe(gap);
      if (k > 0) begin
        check(gap === OSR * BIT_DIV - 40, "strobe spacing");
      end
      repeat (40) @(negedge ref_clk);
      check(angle_word === no_value_word(), "warm-up word");
      check(angle_valid === 1'b1, "word not handed on");
    end
    check(filt_pair.sin_word === 15'h3FFF, "sine full scale");
    check(filt_pair.sin_word > 15'sd0, "sine sign");
    check(filt_pair.cos_word < 15'sd0, "cosine sign");
    diff = int'(filt_pair.cos_word) - expect_filt(cos_lvl);
    check(!$isunknown(filt_pair) && diff * diff < 262144, "cos level");
    // Drain the three queued words under a random ready
    popped = 0;
    for (int n = 0; n < 64 && popped < 3; n++) begin
      angle_ready = 1'($random(seed));
      if (angle_ready) begin
        check(angle_valid === 1'b1, "queue short");
        check(angle_data === no_value_word(), "queued word");
        popped++;
      end
      @(negedge ref_clk);
    end
    angle_ready = 1'b0;
    if (popped != 3) begin
      check(1'b0, "drain timed out");
      summarize();
    end
    check(angle_valid === 1'b0, "queue not empty");
    // Reset in mid-run: cleared at once and still clear after release
    rst = 1'b1;
    @(negedge ref_clk);
    check(angle_word === no_value_word(), "word not cleared");
    check(angle_valid === 1'b0 && filt_strobe === 1'b0, "flags");
    check(filt_pair === '0, "filter pair not cleared");
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(angle_word === no_value_word() && !angle_valid, "release");
    summarize();
  end
endmodule : dac_core_test
